// [asfr_alu.sv]
// Combinational ALU that forms the result and the flags of one instruction.
`timescale 1ns/100ps
`default_nettype none
module asfr_alu (
    // Instruction and effective file operand
    input wire asfr_pkg::asfr_instr_t instr,
    input wire logic [asfr_pkg::DATA_W-1:0] fileVal,
    // Result and flags
    output asfr_pkg::asfr_alu_t res
);
    import asfr_pkg::*;

    logic [DATA_W+1:0] addSum;
    logic [DATA_W+1:0] subSum;
    logic [DATA_W-1:0] bitMask;

    function automatic logic [DATA_W+1:0] addFlags(input logic [DATA_W-1:0] a,
                                                   input logic [DATA_W-1:0] b,
                                                   input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction

    assign addSum = addFlags(instr.wVal, fileVal, 1'b1 & 1'b0);
    // Subtraction adds inverted W plus one, so a carry out means no borrow.
    assign subSum = addFlags(fileVal, ~instr.wVal, 1'b1);
    assign bitMask = 8'h01 << instr.bitSel;

    always_comb begin
        res = '0;
        case (instr.op)
            OP_ADD_W_FILE, OP_ADD_LITERAL: begin
                {res.carry, res.nibble, res.value} = addSum;
                {res.affC, res.affN, res.affZ} = 3'h7;
            end
            OP_SUB_W_FILE, OP_SUB_LITERAL: begin
                {res.carry, res.nibble, res.value} = subSum;
                {res.affC, res.affN, res.affZ} = 3'h7;
            end
            OP_AND: begin
                res.value = instr.wVal & fileVal;
                res.affZ = 1'b1;
            end
            OP_OR: begin
                res.value = instr.wVal | fileVal;
                res.affZ = 1'b1;
            end
            OP_XOR: begin
                res.value = instr.wVal ^ fileVal;
                res.affZ = 1'b1;
            end
            OP_CLEAR_FILE: begin
                res.value = '0;
                res.affZ = 1'b1;
            end
            OP_INC: begin
                res.value = fileVal + 8'h01;
                res.affZ = 1'b1;
            end
            OP_DEC: begin
                res.value = fileVal - 8'h01;
                res.affZ = 1'b1;
            end
            OP_BIT_CLEAR: res.value = fileVal & ~bitMask;
            OP_BIT_SET: res.value = fileVal | bitMask;
            OP_NIBBLE_SWAP: res.value = {fileVal[3:0], fileVal[7:4]};
            OP_MOVE_W_TO_FILE: res.value = instr.wVal;
            default: res.value = '0;
        endcase
        res.zero = (res.value == '0);
    end
endmodule
`default_nettype wire

// [asfr_far_model.sv]
// Far-side model: pin wiring and the datapath that takes back results.
`timescale 1ns/100ps
`default_nettype none
module asfr_far_model #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Datapath side
    input wire logic [7:0] resultData,
    input wire logic resultValid,
    output var logic [7:0] fileReg,
    output var int resultCount,
    // Pin side
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOeN,
    input wire logic [PIN_COUNT-1:0] extLevel,
    output var logic [PIN_COUNT-1:0] pinWire
);
    // A pin follows the core only while its enable is low; otherwise the board drives it.
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pinWire[i] = pinOeN[i] ? extLevel[i] : pinOut[i];
        end
    end
    // One write-back per cycle of resultValid, so a stretched pulse shows up as an extra result.
    always @(posedge core_clk) begin
        if (!resetn) begin
            fileReg <= 8'h00;
            resultCount <= 0;
        end else if (resultValid === 1'b1) begin
            fileReg <= resultData;
            resultCount <= resultCount + 1;
        end
    end
endmodule
`default_nettype wire

// [asfr_pin_ioc.sv]
// Pin synchroniser and level-change flag logic for every general purpose pin.
`timescale 1ns/100ps
`default_nettype none
module asfr_pin_ioc #(
    parameter int PIN_COUNT = 8
) (
    // Clock, reset and clock enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins and controls
    input wire logic [PIN_COUNT-1:0] pinIn,
    input wire logic [PIN_COUNT-1:0] posEn,
    input wire logic [PIN_COUNT-1:0] negEn,
    input wire logic [PIN_COUNT-1:0] flagClr,
    // Status
    output logic [PIN_COUNT-1:0] pinLevel,
    output logic [PIN_COUNT-1:0] flags,
    output logic irq
);
    logic [PIN_COUNT-1:0] syncMeta;
    logic [PIN_COUNT-1:0] lastLevel;
    logic [2:0] warmUp;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [PIN_COUNT-1:0] hits;
    logic [PIN_COUNT-1:0] next_flags;

    // Only the second stage reads the first, so metastability stays contained.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            syncMeta <= '0;
            pinLevel <= '0;
        end else if (ce) begin
            syncMeta <= pinIn;
            pinLevel <= syncMeta;
        end
    end

    // Pins may idle high, so edges count only once the history holds real levels.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            lastLevel <= '0;
            warmUp <= 3'h0;
        end else if (ce) begin
            lastLevel <= pinLevel;
            warmUp <= {warmUp[1:0], 1'b1};
        end
    end

    assign rise = pinLevel & ~lastLevel;
    assign fall = ~pinLevel & lastLevel;
    assign hits = ((rise & posEn) | (fall & negEn)) & {PIN_COUNT{warmUp[2]}};
    // A change seen in the cycle of its clear still sets the flag.
    assign next_flags = (flags & ~flagClr) | hits;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            flags <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            flags <= next_flags;
            irq <= |next_flags;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    ioc_set_a: assert property (ce && (|hits) |=> ((flags & $past(hits)) == $past(hits)))
        else $error("Enabled pin change did not set its flag.");
    ioc_irq_a: assert property (ce |=> (irq == (|flags)))
        else $error("Change interrupt does not follow the flags.");
endmodule
`default_nettype wire

// [asfr_pkg.sv]
// Shared constants and types of the ALU status flag register block.
package asfr_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IOC_POS = 4'h1;
    localparam logic [3:0] ADDR_IOC_NEG = 4'h2;
    localparam logic [3:0] ADDR_IOC_FLAG = 4'h3;
    localparam logic [3:0] ADDR_REMAP = 4'h4;
    localparam logic [3:0] ADDR_PIN_LEVEL = 4'h5;
    localparam int CARRY_POS = 0;
    localparam int NIBBLE_POS = 1;
    localparam int ZERO_POS = 2;
    localparam int PDN_POS = 3;
    localparam int TMO_POS = 4;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] STATUS_IMPL = 8'h1F;
    localparam logic [7:0] TMO_PDN_MASK = 8'h18;
    localparam logic [7:0] IOC_EN_RST = 8'h00;
    localparam logic [7:0] IOC_FLAG_RST = 8'h00;
    localparam logic REMAP_RST = 1'b0;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD_W_FILE = 4'h1,
        OP_ADD_LITERAL = 4'h2,
        OP_SUB_LITERAL = 4'h3,
        OP_SUB_W_FILE = 4'h4,
        OP_AND = 4'h5,
        OP_OR = 4'h6,
        OP_XOR = 4'h7,
        OP_CLEAR_FILE = 4'h8,
        OP_BIT_CLEAR = 4'h9,
        OP_BIT_SET = 4'hA,
        OP_NIBBLE_SWAP = 4'hB,
        OP_MOVE_W_TO_FILE = 4'hC,
        OP_INC = 4'hD,
        OP_DEC = 4'hE
    } asfr_op_t;

    typedef struct packed {
        logic valid;
        asfr_op_t op;
        logic [7:0] wVal;
        logic [7:0] operand;
        logic [2:0] bitSel;
        logic fileIsStatus;
        logic destFile;
    } asfr_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic zero;
        logic nibble;
        logic carry;
        logic affZ;
        logic affN;
        logic affC;
    } asfr_alu_t;
endpackage

// [asfr_status_core.sv]
// Status flag register core with pin change detection and function remap.
`timescale 1ns/100ps
`default_nettype none
module asfr_status_core #(
    parameter int PIN_COUNT = 8,
    parameter int LOC_A = 0,
    parameter int LOC_B = 4
) (
    // Clock, reset and clock enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire logic [asfr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [asfr_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [asfr_pkg::DATA_W-1:0] regRdData,
    // Instruction execution
    input wire asfr_pkg::asfr_instr_t instr,
    output logic [asfr_pkg::DATA_W-1:0] resultData,
    output logic resultValid,
    output logic [asfr_pkg::DATA_W-1:0] statusOut,
    // Reset-cause events
    input wire logic clrWdtEvt,
    input wire logic sleepEvt,
    input wire logic wdtTimeoutEvt,
    // Pins and remapped function
    input wire logic [PIN_COUNT-1:0] pinIn,
    output logic [PIN_COUNT-1:0] pinOut,
    output logic [PIN_COUNT-1:0] pinOeN,
    input wire logic funcOut,
    input wire logic funcDrive,
    output logic funcIn,
    output logic iocIrq
);
    import asfr_pkg::*;

    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] next_status;
    logic [DATA_W-1:0] next_rdData;
    logic [DATA_W-1:0] fileVal;
    logic [PIN_COUNT-1:0] iocPos;
    logic [PIN_COUNT-1:0] iocNeg;
    logic [PIN_COUNT-1:0] iocFlag;
    logic [PIN_COUNT-1:0] iocClr;
    logic [PIN_COUNT-1:0] pinLevel;
    logic remapSel;
    logic toStatus;
    logic flagOp;
    logic anyEvt;
    int activeLoc;
    asfr_alu_t alu;

    function automatic logic wrHit(input logic we,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
        return we && (addr == offset);
    endfunction

    // Status-sourced operands let read-modify-write ops see the live flags.
    assign fileVal = instr.fileIsStatus ? status : instr.operand;
    assign toStatus = instr.valid && instr.fileIsStatus && instr.destFile;
    assign flagOp = alu.affZ || alu.affN || alu.affC;
    assign anyEvt = clrWdtEvt || sleepEvt || wdtTimeoutEvt;
    assign statusOut = status;

    asfr_alu u_alu (
        .instr(instr),
        .fileVal(fileVal),
        .res(alu)
    );

    asfr_pin_ioc #(
        .PIN_COUNT(PIN_COUNT)
    ) u_ioc (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .pinIn(pinIn),
        .posEn(iocPos),
        .negEn(iocNeg),
        .flagClr(iocClr),
        .pinLevel(pinLevel),
        .flags(iocFlag),
        .irq(iocIrq)
    );

    // An instruction aimed at status takes precedence over a software write.
    always_comb begin
        next_status = status;
        if (wrHit(regWr, regAddr, ADDR_STATUS) && !toStatus) begin
            next_status = (regWrData & ~TMO_PDN_MASK) | (status & TMO_PDN_MASK);
        end
        if (toStatus && !flagOp) begin
            next_status = (alu.value & ~TMO_PDN_MASK) | (status & TMO_PDN_MASK);
        end
        if (instr.valid && alu.affZ) begin
            next_status[ZERO_POS] = alu.zero;
        end
        if (instr.valid && alu.affN) begin
            next_status[NIBBLE_POS] = alu.nibble;
        end
        if (instr.valid && alu.affC) begin
            next_status[CARRY_POS] = alu.carry;
        end
        if (clrWdtEvt) begin
            next_status[TMO_POS] = 1'b1;
            next_status[PDN_POS] = 1'b1;
        end
        if (sleepEvt) begin
            next_status[TMO_POS] = 1'b1;
            next_status[PDN_POS] = 1'b0;
        end
        if (wdtTimeoutEvt) begin
            next_status[TMO_POS] = 1'b0;
        end
        next_status = next_status & STATUS_IMPL;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            status <= STATUS_RST;
        end else if (ce) begin
            status <= next_status;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            resultData <= '0;
            resultValid <= 1'b0;
        end else if (ce) begin
            resultValid <= instr.valid && !toStatus;
            if (instr.valid) begin
                resultData <= alu.value;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            iocPos <= IOC_EN_RST[PIN_COUNT-1:0];
            iocNeg <= IOC_EN_RST[PIN_COUNT-1:0];
        end else if (ce) begin
            if (wrHit(regWr, regAddr, ADDR_IOC_POS)) begin
                iocPos <= regWrData[PIN_COUNT-1:0];
            end
            if (wrHit(regWr, regAddr, ADDR_IOC_NEG)) begin
                iocNeg <= regWrData[PIN_COUNT-1:0];
            end
        end
    end

    // Writing a zero clears a flag, so a read-modify-write can drop a flag set after its read.
    always_comb begin
        iocClr = '0;
        if (wrHit(regWr, regAddr, ADDR_IOC_FLAG)) begin
            iocClr = ~regWrData[PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            remapSel <= REMAP_RST;
        end else if (ce) begin
            if (wrHit(regWr, regAddr, ADDR_REMAP)) begin
                remapSel <= regWrData[0];
            end
        end
    end

    assign activeLoc = remapSel ? LOC_B : LOC_A;

    // The unused location is released, so only one pin carries the function.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pinOut <= '0;
            pinOeN <= '1;
            funcIn <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pinOut[i] <= (i == activeLoc) && funcOut;
                pinOeN[i] <= !((i == activeLoc) && funcDrive);
            end
            funcIn <= pinLevel[activeLoc];
        end
    end

    always_comb begin
        next_rdData = '0;
        case (regAddr)
            ADDR_STATUS: next_rdData = status;
            ADDR_IOC_POS: next_rdData = DATA_W'(iocPos);
            ADDR_IOC_NEG: next_rdData = DATA_W'(iocNeg);
            ADDR_IOC_FLAG: next_rdData = DATA_W'(iocFlag);
            ADDR_REMAP: next_rdData = DATA_W'(remapSel);
            ADDR_PIN_LEVEL: next_rdData = DATA_W'(pinLevel);
            default: next_rdData = '0;
        endcase
    end

    // Read data stands one cycle only, which keeps stale values off the bus.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            regRdData <= '0;
        end else if (ce) begin
            regRdData <= regRd ? next_rdData : '0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence quietS;
        ce && !anyEvt;
    endsequence

    sequence toStatusS;
        ce && toStatus;
    endsequence

    sequence swWriteS;
        ce && wrHit(regWr, regAddr, ADDR_STATUS) && !instr.valid;
    endsequence

    tmo_pdn_hold_a: assert property (quietS |=> $stable(status[TMO_POS:PDN_POS]))
        else $error("Timeout or powerdown changed without an event.");

    sw_write_a: assert property (swWriteS ##0 quietS
            |=> status[ZERO_POS:CARRY_POS] == $past(regWrData[ZERO_POS:CARRY_POS]))
        else $error("Software write to status lost its flag bits.");

    flag_block_a: assert property (toStatusS ##0 alu.affC
            |=> status[CARRY_POS] == $past(alu.carry))
        else $error("Flag op on status wrote result bits into carry.");

    clear_file_a: assert property (toStatusS ##0 quietS ##0 (instr.op == OP_CLEAR_FILE)
            |=> status[ZERO_POS] && $stable(status[TMO_POS:PDN_POS])
            && $stable(status[NIBBLE_POS:CARRY_POS]))
        else $error("Clear of status did not give the expected pattern.");

    move_status_a: assert property (toStatusS ##0 quietS ##0 (instr.op == OP_MOVE_W_TO_FILE)
            |=> status[ZERO_POS:CARRY_POS] == $past(instr.wVal[ZERO_POS:CARRY_POS]))
        else $error("Move to status did not write the flag bits.");

    sub_borrow_a: assert property (ce && instr.valid && instr.op == OP_SUB_W_FILE
            |=> status[CARRY_POS] == ($past(fileVal) >= $past(instr.wVal)))
        else $error("Subtract carry does not show no-borrow.");

    nibble_add_a: assert property (ce && instr.valid && instr.op == OP_ADD_W_FILE
            |=> status[NIBBLE_POS] == (({1'b0, $past(fileVal[3:0])}
            + {1'b0, $past(instr.wVal[3:0])}) > 5'h0F))
        else $error("Add nibble carry is wrong.");

    zero_flag_a: assert property (ce && instr.valid && alu.affZ
            |=> status[ZERO_POS] == ($past(alu.value) == '0))
        else $error("Zero flag does not match the result.");

    upper_zero_a: assert property ((status & ~STATUS_IMPL) == '0)
        else $error("Unimplemented status bits are not zero.");

    read_status_a: assert property (ce && regRd && regAddr == ADDR_STATUS
            |=> regRdData == $past(status))
        else $error("Status read returned the wrong value.");

    read_idle_a: assert property (ce && !regRd |=> regRdData == '0)
        else $error("Read data stood outside its cycle.");

    remap_b_a: assert property (ce && funcDrive && remapSel
            |=> !pinOeN[LOC_B] && pinOeN[LOC_A])
        else $error("Function not driven at the alternate pin only.");

    timeout_evt_a: assert property (ce && wdtTimeoutEvt |=> !status[TMO_POS])
        else $error("Watchdog time-out did not clear the timeout flag.");

    sleep_evt_a: assert property (ce && sleepEvt && !clrWdtEvt && !wdtTimeoutEvt
            |=> status[TMO_POS] && !status[PDN_POS])
        else $error("Sleep did not set timeout and clear powerdown.");

    clear_wdt_a: assert property (ce && clrWdtEvt && !sleepEvt && !wdtTimeoutEvt
            |=> status[TMO_POS] && status[PDN_POS])
        else $error("Watchdog clear did not set timeout and powerdown.");

    result_skip_a: assert property (toStatusS |=> !resultValid)
        else $error("Result strobe raised for a status destination.");

    result_data_a: assert property (ce && instr.valid
            |=> resultData == $past(alu.value))
        else $error("Result data does not hold the last operation result.");

    remap_main_a: assert property (ce && funcDrive && !remapSel
            |=> !pinOeN[LOC_A] && pinOeN[LOC_B])
        else $error("Function not driven at the main pin only.");
endmodule
`default_nettype wire

// [asfr_status_core_bench.sv]
// Self-checking bench of the status flag register core.
`timescale 1ns/100ps
`default_nettype none
module asfr_status_core_bench;
    import asfr_pkg::*;
    typedef struct packed {
        asfr_op_t op;
        logic [7:0] w;
        logic [7:0] opd;
        logic [2:0] bs;
        logic st;
        logic [2:0] pre;
        logic [7:0] res;
        logic [2:0] fl;
    } asfr_row_t;
    // Flags are listed as zero, nibble carry, carry; pre is the value loaded first.
    localparam asfr_row_t ROWS [21] = '{
        '{OP_ADD_W_FILE, 8'h08, 8'h08, 3'h0, 1'h0, 3'h0, 8'h10, 3'h2},
        '{OP_ADD_LITERAL, 8'hFF, 8'h01, 3'h0, 1'h0, 3'h0, 8'h00, 3'h7},
        '{OP_SUB_W_FILE, 8'h01, 8'h10, 3'h0, 1'h0, 3'h0, 8'h0F, 3'h1},
        '{OP_SUB_LITERAL, 8'h02, 8'h01, 3'h0, 1'h0, 3'h7, 8'hFF, 3'h0},
        '{OP_SUB_W_FILE, 8'h05, 8'h05, 3'h0, 1'h0, 3'h0, 8'h00, 3'h7},
        '{OP_AND, 8'hF0, 8'h0F, 3'h0, 1'h0, 3'h1, 8'h00, 3'h5},
        '{OP_OR, 8'h0F, 8'hF0, 3'h0, 1'h0, 3'h4, 8'hFF, 3'h0},
        '{OP_XOR, 8'hAA, 8'hAA, 3'h0, 1'h0, 3'h2, 8'h00, 3'h6},
        '{OP_INC, 8'h00, 8'hFF, 3'h0, 1'h0, 3'h0, 8'h00, 3'h4},
        '{OP_DEC, 8'h00, 8'h01, 3'h0, 1'h0, 3'h2, 8'h00, 3'h6},
        '{OP_BIT_SET, 8'h00, 8'h00, 3'h3, 1'h0, 3'h5, 8'h08, 3'h5},
        '{OP_BIT_CLEAR, 8'h00, 8'hFF, 3'h7, 1'h0, 3'h2, 8'h7F, 3'h2},
        '{OP_NIBBLE_SWAP, 8'h00, 8'hA5, 3'h0, 1'h0, 3'h7, 8'h5A, 3'h7},
        '{OP_MOVE_W_TO_FILE, 8'h3C, 8'h00, 3'h0, 1'h0, 3'h0, 8'h3C, 3'h0},
        '{OP_CLEAR_FILE, 8'h00, 8'h55, 3'h0, 1'h0, 3'h2, 8'h00, 3'h6},
        '{OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'h1, 3'h3, 8'h00, 3'h7},
        '{OP_ADD_W_FILE, 8'hE8, 8'h00, 3'h0, 1'h1, 3'h0, 8'h00, 3'h7},
        '{OP_BIT_CLEAR, 8'h00, 8'h00, 3'h4, 1'h1, 3'h0, 8'h00, 3'h0},
        '{OP_BIT_SET, 8'h00, 8'h00, 3'h0, 1'h1, 3'h0, 8'h00, 3'h1},
        '{OP_MOVE_W_TO_FILE, 8'hFF, 8'h00, 3'h0, 1'h1, 3'h0, 8'h00, 3'h7},
        '{OP_NIBBLE_SWAP, 8'h00, 8'h00, 3'h0, 1'h1, 3'h0, 8'h00, 3'h1}
    };
    localparam logic [2:0] EVS [4] = '{3'h2, 3'h1, 3'h4, 3'h5};
    localparam logic [1:0] EVX [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
    localparam int LOCS [2] = '{0, 4};
    logic core_clk = 1'b0;
    logic resetn;
    logic ce;
    logic [3:0] regAddr;
    logic [7:0] regWrData;
    logic regWr;
    logic regRd;
    asfr_instr_t instr;
    logic clrWdtEvt;
    logic sleepEvt;
    logic wdtTimeoutEvt;
    logic funcOut;
    logic funcDrive;
    logic [7:0] extLevel;
    logic [7:0] regRdData;
    logic [7:0] resultData;
    logic [7:0] statusOut;
    logic [7:0] pinOut;
    logic [7:0] pinOeN;
    logic [7:0] pinWire;
    logic [7:0] fileReg;
    logic [7:0] rdv;
    logic resultValid;
    logic funcIn;
    logic iocIrq;
    int resultCount;
    int errCount = 0;
    int compares = 0;

    always #5 core_clk = ~core_clk;

    asfr_status_core #(.PIN_COUNT(8), .LOC_A(0), .LOC_B(4)) u_asfr_status_core (
        .core_clk(core_clk), .resetn(resetn), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .instr(instr), .resultData(resultData),
        .resultValid(resultValid), .statusOut(statusOut), .clrWdtEvt(clrWdtEvt),
        .sleepEvt(sleepEvt), .wdtTimeoutEvt(wdtTimeoutEvt), .pinIn(pinWire),
        .pinOut(pinOut), .pinOeN(pinOeN), .funcOut(funcOut), .funcDrive(funcDrive),
        .funcIn(funcIn), .iocIrq(iocIrq)
    );
    asfr_far_model #(.PIN_COUNT(8)) u_asfr_far_model (
        .core_clk(core_clk), .resetn(resetn), .resultData(resultData),
        .resultValid(resultValid), .fileReg(fileReg), .resultCount(resultCount),
        .pinOut(pinOut), .pinOeN(pinOeN), .extLevel(extLevel), .pinWire(pinWire)
    );

    task automatic end_of_test;
        $display("errors %0d compares %0d", errCount, compares);
        if (errCount == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string msg);
        chk8({7'h00, got}, {7'h00, exp}, msg);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic exec(input asfr_row_t r);
        @(posedge core_clk);
        instr <= '{1'b1, r.op, r.w, r.opd, r.bs, r.st, 1'b1};
        @(posedge core_clk);
        instr.valid <= 1'b0;
        #1;
    endtask
    task automatic pulse(input logic [2:0] ev);
        @(posedge core_clk);
        {clrWdtEvt, sleepEvt, wdtTimeoutEvt} <= ev;
        @(posedge core_clk);
        {clrWdtEvt, sleepEvt, wdtTimeoutEvt} <= 3'h0;
        #1;
    endtask
    // Bounded so that a dead change detector ends the run instead of hanging it.
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        #1;
        while (iocIrq !== lvl && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk1(iocIrq, lvl, "irq wait");
        if (iocIrq !== lvl) begin
            end_of_test();
        end
    endtask

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        instr = '0;
        {clrWdtEvt, sleepEvt, wdtTimeoutEvt} = 3'h0;
        funcOut = 1'b0;
        funcDrive = 1'b0;
        extLevel = 8'h00;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (ROWS[i]) begin
            wr(ADDR_STATUS, {5'h00, ROWS[i].pre});
            exec(ROWS[i]);
            chk8(statusOut, {5'h03, ROWS[i].fl}, "status");
            chk1(resultValid, !ROWS[i].st, "valid");
            if (!ROWS[i].st) begin
                chk8(resultData, ROWS[i].res, "result");
                @(posedge core_clk);
                #1;
                chk8(fileReg, ROWS[i].res, "write-back");
            end
        end
        chk8(resultCount[7:0], 8'h0F, "results");
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk8(statusOut, STATUS_RST, "reset status");
        chk8(pinOeN, 8'hFF, "reset oe");
        chk1(resultValid, 1'b0, "reset valid");
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, rdv);
        chk8(rdv, 8'h1F, "status read");
        @(posedge core_clk);
        #1;
        chk8(regRdData, 8'h00, "read idle");
        rd(4'hF, rdv);
        chk8(rdv, 8'h00, "unmapped");
        wr(ADDR_STATUS, 8'h00);
        #1;
        chk8(statusOut, 8'h18, "tmo write");
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= ADDR_STATUS;
        regWrData <= 8'h07;
        instr <= '{1'b1, OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b1, 1'b1};
        @(posedge core_clk);
        regWr <= 1'b0;
        instr.valid <= 1'b0;
        #1;
        chk8(statusOut, 8'h1C, "instr beats write");
        @(posedge core_clk);
        ce <= 1'b0;
        exec(ROWS[0]);
        chk1(resultValid, 1'b0, "frozen valid");
        chk8(statusOut, 8'h1C, "frozen status");
        @(posedge core_clk);
        ce <= 1'b1;
        foreach (EVS[i]) begin
            pulse(EVS[i]);
            chk8(statusOut, {3'h0, EVX[i], 3'h4}, "event");
        end
        wr(ADDR_IOC_POS, 8'h01);
        wr(ADDR_IOC_NEG, 8'h02);
        extLevel <= 8'h03;
        wait_irq(1'b1);
        rd(ADDR_IOC_FLAG, rdv);
        chk8(rdv, 8'h01, "rise flag");
        rd(ADDR_PIN_LEVEL, rdv);
        chk8(rdv, 8'h03, "pin level");
        wr(ADDR_IOC_FLAG, 8'h00);
        wait_irq(1'b0);
        @(posedge core_clk);
        extLevel <= 8'h00;
        wait_irq(1'b1);
        rd(ADDR_IOC_FLAG, rdv);
        chk8(rdv, 8'h02, "fall flag");
        @(posedge core_clk);
        funcOut <= 1'b1;
        funcDrive <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_REMAP, 8'(s));
            repeat (6) @(posedge core_clk);
            #1;
            chk8(pinOeN, ~(8'h01 << LOCS[s]), "remap oe");
            chk8(pinOut, 8'h01 << LOCS[s], "remap out");
            chk1(funcIn, 1'b1, "remap in");
        end
        @(posedge core_clk);
        funcDrive <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk8(pinOeN, 8'hFF, "drive off");
        end_of_test();
    end
endmodule
`default_nettype wire
